// ===== ifr_regs.vh
// Purpose: constants for the interrupt pending flag register block
// Assumes: 16-bit register port, one word per address
// Notes:   layout follows the base variant with host port and buffered serial bits
`ifndef IFR_REGS_VH
`define IFR_REGS_VH

// =====================================
// register offsets
`define IFR_ADDR_W            4
`define IFR_OFF_PENDING       4'h0
`define IFR_OFF_MASK          4'h1
`define IFR_OFF_CTRL          4'h2
`define IFR_OFF_TAKEN         4'h3

// =====================================
// field positions and widths
`define IFR_W                 16
`define IFR_NUM_W             4
`define IFR_BIT_EXT0          0
`define IFR_BIT_EXT1          1
`define IFR_BIT_EXT2          2
`define IFR_BIT_TIMER         3
`define IFR_BIT_BSER_RX       4
`define IFR_BIT_BSER_TX       5
`define IFR_BIT_SER_RX        6
`define IFR_BIT_SER_TX        7
`define IFR_BIT_EXT3          8
`define IFR_BIT_HOST          9
`define IFR_CTRL_GDIS         0

// =====================================
// reset values and implemented bits
`define IFR_RST_PENDING       16'h0000
`define IFR_RST_MASK          16'h0000
`define IFR_RST_GDIS          1'b1
`define IFR_IMPL_MASK         16'h03FF

`endif

// ===== ifr_prio.v
// Purpose: fixed priority pick among eligible pending flags
// Assumes: bit 0 is priority 1, highest
// Notes:   purely combinational
`include "ifr_regs.vh"

module ifr_prio (
    // eligible flags
    input  wire [`IFR_W-1:0]     i_elig,
    // chosen source
    output reg                   o_any,
    output reg  [`IFR_NUM_W-1:0] o_num
);
    integer k;

    // =====================================
    // lowest index wins
    always @* begin
        o_any = 1'b0;
        o_num = 4'h0;
        for (k = `IFR_W - 1; k >= 0; k = k - 1) begin
            if (i_elig[k]) begin
                o_any = 1'b1;
                o_num = k[`IFR_NUM_W-1:0];
            end
        end
    end
endmodule // ifr_prio

// ===== ifr_dec.v
// Purpose: one-hot decode of an interrupt number with enable
// Assumes: number below 16
// Notes:   used for trap and software interrupt clears
`include "ifr_regs.vh"

module ifr_dec (
    // request
    input  wire                  i_en,
    input  wire [`IFR_NUM_W-1:0] i_num,
    // one-hot result
    output wire [`IFR_W-1:0]     o_onehot
);
    // =====================================
    // decode
    assign o_onehot = i_en ? (16'h0001 << i_num) : 16'h0000;
endmodule // ifr_dec

// ===== ifr_flags.v
// Purpose: pending interrupt flag register with mask, disable and pick
// Assumes: sources give one-cycle pulses or levels synchronous to i_clk_sys
// Notes:   read data valid only in the cycle after the read strobe
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`include "ifr_regs.vh"

module ifr_flags (
    // clock, reset, enable
    input  wire                   i_clk_sys,
    input  wire                   i_srst,
    input  wire                   i_ce,
    input  wire                   i_core_reset_low,
    // interrupt sources
    input  wire                   i_ext_request_line_0,
    input  wire                   i_ext_request_line_1,
    input  wire                   i_ext_request_line_2,
    input  wire                   i_ext_request_line_3,
    input  wire                   i_timer_event_flag,
    input  wire                   i_buffered_serial0_receive_event,
    input  wire                   i_buffered_serial0_transmit_event,
    input  wire                   i_serial0_receive_event,
    input  wire                   i_serial0_transmit_event,
    input  wire                   i_host_port_event,
    // cpu acknowledge side
    input  wire                   i_trap_take,
    input  wire                   i_soft_irq_instruction,
    input  wire [`IFR_NUM_W-1:0]  i_soft_irq_num,
    // register port
    input  wire [`IFR_ADDR_W-1:0] i_addr,
    input  wire [`IFR_W-1:0]      i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output reg  [`IFR_W-1:0]      o_rdata,
    // interrupt request to cpu
    output wire                   o_irq,
    output wire [`IFR_NUM_W-1:0]  o_irq_num,
    output wire [`IFR_W-1:0]      o_pending
);
    // =====================================
    // state
    reg  [`IFR_W-1:0]     pending_ff;
    reg  [`IFR_W-1:0]     nxt_pending;
    reg  [`IFR_W-1:0]     mask_ff;
    reg                   gdis_ff;
    reg  [`IFR_NUM_W-1:0] taken_ff;
    reg                   taken_vld_ff;

    wire [`IFR_W-1:0]     req_vec;
    wire [`IFR_W-1:0]     trap_clr;
    wire [`IFR_W-1:0]     soft_clr;
    wire [`IFR_W-1:0]     sw_clr;
    wire [`IFR_W-1:0]     elig;
    wire                  any_elig;
    wire [`IFR_NUM_W-1:0] pick_num;

    function [`IFR_W-1:0] impl;
        input [`IFR_W-1:0] v;
        begin
            impl = v & `IFR_IMPL_MASK;
        end
    endfunction

    // =====================================
    // source mapping
    assign req_vec = {6'h00,
                      i_host_port_event,
                      i_ext_request_line_3,
                      i_serial0_transmit_event,
                      i_serial0_receive_event,
                      i_buffered_serial0_transmit_event,
                      i_buffered_serial0_receive_event,
                      i_timer_event_flag,
                      i_ext_request_line_2,
                      i_ext_request_line_1,
                      i_ext_request_line_0};

    // =====================================
    // clear sources
    ifr_dec u_trap_dec (
        .i_en     (i_trap_take & any_elig),
        .i_num    (pick_num),
        .o_onehot (trap_clr)
    );

    ifr_dec u_soft_dec (
        .i_en     (i_soft_irq_instruction),
        .i_num    (i_soft_irq_num),
        .o_onehot (soft_clr)
    );

    // writing back the read value clears what was read as pending, except bits whose request is set in the same cycle
    assign sw_clr = (i_wr && i_addr == `IFR_OFF_PENDING) ? i_wdata : 16'h0000;

    // =====================================
    // eligibility and priority
    assign elig = gdis_ff ? 16'h0000 : (pending_ff & mask_ff);

    ifr_prio u_prio (
        .i_elig (elig),
        .o_any  (any_elig),
        .o_num  (pick_num)
    );

    assign o_irq     = any_elig;
    assign o_irq_num = pick_num;
    assign o_pending = pending_ff;

    // =====================================
    // next pending value
    always @* begin
        nxt_pending = pending_ff & ~(trap_clr | soft_clr | sw_clr);
        nxt_pending = impl(nxt_pending | req_vec);
    end

    // =====================================
    // registers
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            pending_ff   <= `IFR_RST_PENDING;
            mask_ff      <= `IFR_RST_MASK;
            gdis_ff      <= `IFR_RST_GDIS;
            taken_ff     <= 4'h0;
            taken_vld_ff <= 1'b0;
            o_rdata      <= 16'h0000;
        end else if (i_ce) begin
            if (!i_core_reset_low) begin
                pending_ff <= `IFR_RST_PENDING;
                gdis_ff    <= `IFR_RST_GDIS;
            end else begin
                pending_ff <= nxt_pending;
                if (i_wr && i_addr == `IFR_OFF_CTRL)
                    gdis_ff <= i_wdata[`IFR_CTRL_GDIS];
            end
            if (i_wr && i_addr == `IFR_OFF_MASK)
                mask_ff <= impl(i_wdata);
            if (i_trap_take && any_elig) begin
                taken_ff     <= pick_num;
                taken_vld_ff <= 1'b1;
            end
            o_rdata <= 16'h0000;
            if (i_rd) begin
                case (i_addr)
                    `IFR_OFF_PENDING: o_rdata <= pending_ff;
                    `IFR_OFF_MASK:    o_rdata <= mask_ff;
                    `IFR_OFF_CTRL:    o_rdata <= {15'h0000, gdis_ff};
                    `IFR_OFF_TAKEN:   o_rdata <= {11'h000, taken_vld_ff, taken_ff};
                    default:          o_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule // ifr_flags

// ===== ifr_cpu_model.sv
// Purpose: cpu side that takes a trap while enabled when a request is offered
// Assumes: the block ignores a take while no request stands
// Notes:   takes every other cycle so the block's clear lands first
module ifr_cpu_model (
    // clock and control
    input  wire logic i_clk_sys,
    input  wire logic i_en,
    // request and acknowledge
    input  wire logic i_irq,
    output logic      o_trap_take
);
    timeunit 1ns;
    timeprecision 1ps;
    logic trap_ff = 1'b0;
    assign o_trap_take = trap_ff;
    // ==========
    // take logic
    always @(posedge i_clk_sys) begin
        trap_ff <= i_en && i_irq && !trap_ff;
    end
endmodule // ifr_cpu_model

// ===== ifr_flags_checker.sv
// Purpose: port-level assertions on the pending flag block
// Assumes: bit 0 stands for all sources
// Notes:   bound to every ifr_flags instance
module ifr_flags_checker (
    input wire        i_clk_sys, i_srst, i_ce, i_core_reset_low, i_ext_request_line_0,
    input wire        i_trap_take, i_soft_irq_instruction, i_wr, i_rd, o_irq,
    input wire [3:0]  i_soft_irq_num, i_addr, o_irq_num,
    input wire [15:0] i_wdata, o_rdata, o_pending
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    wire live = i_ce && i_core_reset_low;
    wire wr0  = i_wr && i_addr == 4'h0 && i_wdata[0];
    sequence req0_s;
        live && i_ext_request_line_0;
    endsequence
    sequence w1c0_s;
        live && wr0 && !i_ext_request_line_0;
    endsequence
    // ==========
    // assertions
    req_sets_a: assert property (req0_s |=> o_pending[0]) else $error("request lost");
    w1c_clear_a: assert property (w1c0_s |=> !o_pending[0]) else $error("w1c fail");
    core_rst_a: assert property (i_ce && !i_core_reset_low |=> o_pending == 16'h0000)
        else $error("core reset fail");
    rsvd_zero_a: assert property (o_pending[15:10] == 6'h00) else $error("reserved set");
    rd_data_a: assert property (i_ce && i_rd && i_addr == 4'h0 |=> o_rdata == $past(o_pending))
        else $error("read data wrong");
    rd_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000) else $error("rdata stale");
    flag_hold_a: assert property (live && o_pending[0] && !i_trap_take && !i_soft_irq_instruction && !wr0
        |=> o_pending[0]) else $error("flag dropped");
    trap_clr_a: assert property (live && i_trap_take && o_irq && o_irq_num == 4'h0 && !i_ext_request_line_0
        |=> !o_pending[0]) else $error("trap clear fail");
    soft_clr_a: assert property (live && i_soft_irq_instruction && i_soft_irq_num == 4'h0
        && !i_ext_request_line_0 |=> !o_pending[0]) else $error("soft clear fail");
    irq_src_a: assert property (o_irq |-> o_pending[o_irq_num]) else $error("irq without flag");
endmodule // ifr_flags_checker

bind ifr_flags ifr_flags_checker ifr_flags_checker_inst (.i_clk_sys, .i_srst, .i_ce, .i_core_reset_low,
    .i_ext_request_line_0, .i_trap_take, .i_soft_irq_instruction, .i_wr, .i_rd, .o_irq, .i_soft_irq_num,
    .i_addr, .o_irq_num, .i_wdata, .o_rdata, .o_pending);

// ===== test_interrupt_flag_register.sv
// Purpose: self-checking bench for the pending flag block
// Assumes: strobes change just after rising edges
// Notes:   sources packed into one vector in flag bit order
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module test_interrupt_flag_register;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 0, i_srst = 1, i_core_reset_low = 1, i_wr = 0, i_rd = 0, cpu_en = 0, i_ce = 1;
    logic        i_soft_irq_instruction = 0, i_trap_take, o_irq;
    logic [3:0]  i_soft_irq_num = 4'h0, i_addr = 4'h0, o_irq_num;
    logic [15:0] i_wdata = 16'h0000, o_rdata, o_pending;
    logic [9:0]  src = 10'h000;
    int          err_count = 0, compares = 0;
    ifr_flags ifr_flags_inst (.i_clk_sys, .i_srst, .i_ce, .i_core_reset_low, .i_ext_request_line_0(src[0]),
        .i_ext_request_line_1(src[1]), .i_ext_request_line_2(src[2]), .i_ext_request_line_3(src[8]),
        .i_timer_event_flag(src[3]), .i_buffered_serial0_receive_event(src[4]),
        .i_buffered_serial0_transmit_event(src[5]), .i_serial0_receive_event(src[6]),
        .i_serial0_transmit_event(src[7]), .i_host_port_event(src[9]), .i_trap_take, .i_soft_irq_instruction,
        .i_soft_irq_num, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .o_irq_num, .o_pending);
    ifr_cpu_model ifr_cpu_model_inst (.i_clk_sys, .i_en(cpu_en), .i_irq(o_irq), .o_trap_take(i_trap_take));
    initial forever #2 i_clk_sys = ~i_clk_sys;
    // ==========
    // access tasks
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 `CHK("rdata", e, o_rdata)
    endtask
    task automatic pulse(input logic [9:0] v);
        @(posedge i_clk_sys);
        src <= v;
        @(posedge i_clk_sys);
        src <= 10'h000;
    endtask
    task automatic final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0001);
        rd(4'hF, 16'h0000);
        pulse(10'h3FF);
        rd(4'h0, 16'h03FF);
        wr(4'h0, 16'h03FF);
        rd(4'h0, 16'h0000);
        pulse(10'h3FF);
        @(posedge i_clk_sys) i_soft_irq_instruction <= 1'b1;
        @(posedge i_clk_sys) i_soft_irq_instruction <= 1'b0;
        rd(4'h0, 16'h03FE);
        @(posedge i_clk_sys) src <= 10'h008;
        wr(4'h0, 16'hFFFF);
        src <= 10'h000;
        rd(4'h0, 16'h0008);
        wr(4'h0, 16'h0008);
        rd(4'h0, 16'h0000);
        pulse(10'h3FF);
        @(posedge i_clk_sys) i_core_reset_low <= 1'b0;
        @(posedge i_clk_sys) i_core_reset_low <= 1'b1;
        rd(4'h0, 16'h0000);
        wr(4'h1, 16'h0009);
        wr(4'h2, 16'h0000);
        pulse(10'h109);
        #1 `CHK("irq", 1'b1, o_irq)
        `CHK("irq_num", 4'h0, o_irq_num)
        @(posedge i_clk_sys) cpu_en <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        cpu_en <= 1'b0;
        rd(4'h0, 16'h0100);
        rd(4'h3, 16'h0013);
        wr(4'h2, 16'h0001);
        pulse(10'h001);
        #1 `CHK("irq", 1'b0, o_irq)
        rd(4'h0, 16'h0101);
        // enable low: requests and writes must leave the flags untouched
        @(posedge i_clk_sys) i_ce <= 1'b0;
        pulse(10'h3FF);
        wr(4'h0, 16'h0101);
        #1 `CHK("pending", 16'h0101, o_pending)
        @(posedge i_clk_sys) i_ce <= 1'b1;
        rd(4'h0, 16'h0101);
        final_report;
    end
    initial begin
        repeat (2000) @(posedge i_clk_sys);
        err_count++;
        final_report;
    end
endmodule // test_interrupt_flag_register
